// [src/ssm_pkg.sv]
/*
  Constants, states and widths shared by the serial port core and its
  transmit FIFO.
  Assumes a single 125 MHz clock domain and no register bus.
*/
// Notes on behaviour
// - I2C sends bits 7..0 MSB first, then ack
// - SDA delay none or 2..8 source ticks
// - SDA disable forces data pin released in two-wire mode only
// - Layout 0 stores bits 7..0, ack ninth
// - Layout 1 stores bits 6..0 and bit 8
// - Layout 1 with phase 1 reads like layout 0
// - Ack force drives its value on SDA unless condition generation is selected
// - Ninth rise sample raises ack or nack in layout 0 only
// - Ack detection can request either DMA channel
// - Start reloads transmit shifter, holds output level
// - Start clears receive shifter, restarts reception
// - Start sets SCL wait, hold after ninth
// - Start-initiated frame leaves empty flag alone
// - Synchronous frames carry exactly eight bits
// - Master clock is source over 2(n+1)
// - Transmit interrupt at load or completion
// - Overrun flagged at seventh bit if unread
// - Bit order, inversion and continuous receive
// - Polarity and phase give four clock modes
// - Overrun leaves receive interrupt unraised
package ssm_pkg;
  localparam logic [2:0] SMD_OFF = 3'h0;
  localparam logic [2:0] SMD_SYNC = 3'h1;
  localparam logic [2:0] SMD_I2C = 3'h2;
  // Count-source prescale limits (divide by 1, 2, 8, 32)
  localparam logic [4:0] PRE_LIM_1 = 5'h00;
  localparam logic [4:0] PRE_LIM_2 = 5'h01;
  localparam logic [4:0] PRE_LIM_8 = 5'h07;
  localparam logic [4:0] PRE_LIM_32 = 5'h1f;
  localparam int DATA_W = 8;
  localparam int RX_W = 9;
  localparam int FIFO_DEPTH = 32;
  localparam logic [3:0] BITS_SYNC = 4'h8;
  localparam logic [3:0] BITS_I2C = 4'h9;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] OVR_SLOT = 4'h6;
  localparam logic [7:0] DUMMY_BYTE = 8'hff;
  localparam logic [2:0] DLY_NONE = 3'h0;
  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_SHIFT = 1'b1} ssm_state_t;
endpackage

// [src/ssm_fifo.sv]
/*
  Transmit FIFO with valid/ready on both sides and parameter width/depth.
  Assumes depth is a power of two; storage is a flop array.
*/
`timescale 1ns/100ps
module ssm_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW:0] wr_q, wr_d, rd_q, rd_d;
  logic push, pop;

  // Full when pointers differ only in the wrap bit
  assign in_ready_o = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid_o = (wr_q != rd_q);
  assign out_data_o = mem_q[rd_q[AW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Pointer advance
  always_comb begin
    wr_d = push ? wr_q + (AW+1)'(1) : wr_q;
    rd_d = pop ? rd_q + (AW+1)'(1) : rd_q;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // Storage written on push only
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end
endmodule

// [src/ssm_serial_port.sv]
/*
  Serial channel core: I2C data path and clocked synchronous mode, with
  a 32-word transmit FIFO in front of the transmit buffer.
  Assumes control bits are driven by software-facing logic on clk_i and
  that pin inputs are asynchronous; pins are split into in/out/enable.
*/
`timescale 1ns/100ps
module ssm_serial_port import ssm_pkg::*; (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [2:0] serial_mode_select_i,
  input wire logic two_wire_mode_select_i,
  input wire logic two_wire_rx_layout_select_i,
  input wire logic [2:0] sda_delay_select_i,
  input wire logic sda_disable_i,
  input wire logic sda_init_i,
  input wire logic clock_phase_select_i,
  input wire logic clock_polarity_select_i,
  input wire logic condition_generation_select_i,
  input wire logic ack_force_enable_i,
  input wire logic ack_force_value_i,
  input wire logic start_initialisation_enable_i,
  input wire logic scl_wait_clear_i,
  input wire logic transmit_enable_i,
  input wire logic receive_enable_i,
  input wire logic clock_direction_select_i,
  input wire logic [7:0] baud_divider_i,
  input wire logic [1:0] count_source_select_i,
  input wire logic transmit_interrupt_source_select_i,
  input wire logic msb_first_i,
  input wire logic invert_data_i,
  input wire logic continuous_rx_i,
  input wire logic [1:0] dma_channel_enable_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic [7:0] tx_data_i,
  input wire logic rx_read_i,
  input wire logic overrun_clear_i,
  output logic [8:0] receive_buffer_o,
  output logic rx_full_o,
  output logic overrun_error_o,
  output logic transmit_buffer_empty_flag_o,
  output logic scl_wait_enable_o,
  output logic busy_o,
  output logic tx_irq_o,
  output logic rx_irq_o,
  output logic ack_irq_o,
  output logic nack_irq_o,
  output logic [1:0] dma_req_o,
  input wire logic serial_data_pin_i,
  output logic serial_data_pin_o,
  output logic serial_data_pin_oe_o,
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_o
);
  logic active, i2c, dir, fifo_v, pop, pre_tick, tclk, out_edge, samp_edge, start_det, start_init;
  logic head, rb, sda_del, ack_slot, load_ok;
  logic [7:0] load_byte, tx_byte, rx_next, rx_byte;
  logic [4:0] pre_lim;
  logic [3:0] last_cnt;

  // Pin synchronisers: bit 0 data pin, bit 1 clock pin
  logic [1:0] s1_q, s2_q, s3_q, f_q, f_d, pf_q;
  always_comb begin
    f_d = (~(s2_q ^ s3_q) & s2_q) | ((s2_q ^ s3_q) & f_q);
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_q <= 2'h3;
      s2_q <= 2'h3;
      s3_q <= 2'h3;
      f_q <= 2'h3;
      pf_q <= 2'h3;
    end else begin
      s1_q <= {serial_clock_pin_i, serial_data_pin_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q <= f_d;
      pf_q <= f_q;
    end
  end

  assign active = (serial_mode_select_i != SMD_OFF);
  assign i2c = active && two_wire_mode_select_i;
  assign dir = clock_direction_select_i;
  assign start_det = i2c && pf_q[0] && !f_q[0] && f_q[1] && pf_q[1];
  assign start_init = start_det && start_initialisation_enable_i;

  // Transmit FIFO in front of the transmit buffer
  ssm_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .in_data_i(tx_data_i),
    .out_valid_o(fifo_v),
    .out_ready_i(pop),
    .out_data_o(load_byte)
  );
  assign transmit_buffer_empty_flag_o = !fifo_v;

  // Count source prescaler and baud divider, master clock 2(n+1) ticks
  ssm_state_t st_q, st_d;
  logic [4:0] pre_q, pre_d;
  logic [7:0] brg_q, brg_d;
  logic int_clk_q, int_clk_d, tclk_q;
  always_comb begin
    unique case (count_source_select_i)
      2'h0: pre_lim = PRE_LIM_1;
      2'h1: pre_lim = PRE_LIM_2;
      2'h2: pre_lim = PRE_LIM_8;
      2'h3: pre_lim = PRE_LIM_32;
    endcase
    pre_tick = (pre_q == pre_lim);
    pre_d = pre_tick ? 5'h00 : pre_q + 5'h01;
    brg_d = brg_q;
    int_clk_d = int_clk_q;
    if (st_q != ST_SHIFT || dir || !active) begin
      brg_d = 8'h00;
      int_clk_d = i2c ? 1'b1 : !clock_polarity_select_i;
    end else if (pre_tick) begin
      if (brg_q == baud_divider_i) begin
        brg_d = 8'h00;
        int_clk_d = !int_clk_q;
      end else begin
        brg_d = brg_q + 8'h01;
      end
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pre_q <= 5'h00;
      brg_q <= 8'h00;
      int_clk_q <= 1'b1;
      tclk_q <= 1'b1;
    end else begin
      pre_q <= pre_d;
      brg_q <= brg_d;
      int_clk_q <= int_clk_d;
      tclk_q <= tclk;
    end
  end

  // Transfer clock edges; outside I2C polarity xor phase picks the output edge, I2C always uses the fall
  assign tclk = dir ? f_q[1] : int_clk_q;
  always_comb begin
    logic rise, fall, sel;
    rise = tclk && !tclk_q;
    fall = !tclk && tclk_q;
    sel = !i2c && (clock_polarity_select_i ^ clock_phase_select_i);
    out_edge = sel ? rise : fall;
    samp_edge = sel ? fall : rise;
  end

  // Frame engine: shifters, bit count, receive buffer and events
  logic [3:0] cnt_q, cnt_d;
  logic [8:0] tx_sh_q, tx_sh_d, rx_buf_q, rx_buf_d;
  logic [7:0] rx_sh_q, rx_sh_d;
  logic dout_q, dout_d, full_q, full_d, ovr_q, ovr_d, ovf_q, ovf_d, sent_q, sent_d;
  logic wait9_q, wait9_d, hold_q, hold_d, swc_q, swc_d;
  logic txi_d, rxi_d, ack_d, nack_d;
  logic txi_q, rxi_q, ack_q, nack_q;
  assign ack_slot = (ack_force_enable_i && !condition_generation_select_i) ? ack_force_value_i : 1'b1;
  assign tx_byte = (invert_data_i && !i2c) ? ~load_byte : load_byte;
  assign head = (msb_first_i || i2c) ? tx_sh_q[8] : tx_sh_q[0];
  assign rb = f_q[0] ^ (invert_data_i && !i2c);
  assign rx_next = (msb_first_i || i2c) ? {rx_sh_q[6:0], rb} : {rb, rx_sh_q[7:1]};
  assign rx_byte = i2c ? rx_sh_q : rx_next;
  assign last_cnt = i2c ? BITS_I2C - 4'h1 : BITS_SYNC - 4'h1;
  assign load_ok = active && transmit_enable_i
    && (fifo_v || (continuous_rx_i && receive_enable_i && rx_read_i && !dir));
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    tx_sh_d = tx_sh_q;
    rx_sh_d = rx_sh_q;
    rx_buf_d = rx_buf_q;
    dout_d = dout_q;
    ovf_d = ovf_q;
    sent_d = sent_q;
    wait9_d = wait9_q;
    hold_d = hold_q;
    pop = 1'b0;
    txi_d = 1'b0;
    rxi_d = 1'b0;
    ack_d = 1'b0;
    nack_d = 1'b0;
    full_d = full_q && !rx_read_i;
    ovr_d = ovr_q && !overrun_clear_i;
    swc_d = start_init || (swc_q && !scl_wait_clear_i);
    if (!active) begin
      st_d = ST_IDLE;
      dout_d = sda_init_i;
      hold_d = 1'b0;
      wait9_d = 1'b0;
    end else if (start_init) begin
      // Restart without touching the FIFO; pin level kept until first bit
      st_d = ST_SHIFT;
      cnt_d = 4'h0;
      tx_sh_d = {(fifo_v ? load_byte : DUMMY_BYTE), ack_slot};
      rx_sh_d = 8'h00;
      ovf_d = 1'b0;
      sent_d = 1'b0;
      hold_d = 1'b0;
      wait9_d = 1'b0;
    end else if (st_q == ST_IDLE) begin
      if (load_ok) begin
        st_d = ST_SHIFT;
        cnt_d = 4'h0;
        pop = fifo_v;
        sent_d = fifo_v;
        txi_d = fifo_v && !transmit_interrupt_source_select_i;
        ovf_d = 1'b0;
        hold_d = 1'b0;
        if (i2c) begin
          tx_sh_d = {(fifo_v ? load_byte : DUMMY_BYTE), ack_slot};
        end else if (msb_first_i) begin
          tx_sh_d = {tx_byte, 1'b1};
        end else begin
          tx_sh_d = {1'b1, tx_byte};
        end
        // On the master clock the sample edge comes first whenever phase is 1; bit one is presented now only when polarity xor phase is 1
        if (!i2c && (clock_polarity_select_i ^ clock_phase_select_i)) begin
          dout_d = msb_first_i ? tx_byte[7] : tx_byte[0];
          tx_sh_d = msb_first_i ? {tx_byte[6:0], 2'h3} : {2'h3, tx_byte[7:1]};
        end
      end
    end else begin
      if (out_edge) begin
        dout_d = head;
        tx_sh_d = (msb_first_i || i2c) ? {tx_sh_q[7:0], 1'b1} : {1'b1, tx_sh_q[8:1]};
      end
      if (samp_edge) begin
        cnt_d = cnt_q + 4'h1;
        if (!(i2c && cnt_q == ACK_SLOT)) begin
          rx_sh_d = rx_next;
        end
        if (cnt_q == OVR_SLOT && full_q && !rx_read_i) begin
          ovr_d = 1'b1;
          ovf_d = 1'b1;
        end
        if (i2c && cnt_q == ACK_SLOT && !two_wire_rx_layout_select_i) begin
          ack_d = !f_q[0];
          nack_d = f_q[0];
        end
        if (cnt_q == last_cnt) begin
          st_d = ST_IDLE;
          wait9_d = i2c;
          txi_d = sent_q && transmit_interrupt_source_select_i;
          if (receive_enable_i) begin
            if (i2c && two_wire_rx_layout_select_i && !clock_phase_select_i) begin
              rx_buf_d = {rx_byte[0], 1'b0, rx_byte[7:1]};
            end else if (i2c) begin
              rx_buf_d = {rb, rx_byte};
            end else begin
              rx_buf_d = {1'b0, rx_byte};
            end
            rxi_d = !ovf_d;
            full_d = full_d || !ovf_d;
          end
        end
      end
    end
    // SCL held low from the ninth falling edge while wait is on
    if (wait9_q && !tclk && tclk_q && st_q == ST_IDLE) begin
      wait9_d = 1'b0;
      hold_d = swc_q;
    end
    if (!swc_q) begin
      hold_d = 1'b0;
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      tx_sh_q <= 9'h1ff;
      rx_sh_q <= 8'h00;
      rx_buf_q <= 9'h000;
      dout_q <= 1'b1;
      full_q <= 1'b0;
      ovr_q <= 1'b0;
      ovf_q <= 1'b0;
      sent_q <= 1'b0;
      wait9_q <= 1'b0;
      hold_q <= 1'b0;
      swc_q <= 1'b0;
      txi_q <= 1'b0;
      rxi_q <= 1'b0;
      ack_q <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      tx_sh_q <= tx_sh_d;
      rx_sh_q <= rx_sh_d;
      rx_buf_q <= rx_buf_d;
      dout_q <= dout_d;
      full_q <= full_d;
      ovr_q <= ovr_d;
      ovf_q <= ovf_d;
      sent_q <= sent_d;
      wait9_q <= wait9_d;
      hold_q <= hold_d;
      swc_q <= swc_d;
      txi_q <= txi_d;
      rxi_q <= rxi_d;
      ack_q <= ack_d;
      nack_q <= nack_d;
    end
  end

  // SDA delay line clocked by the count source, tap 1..7 gives 2..8 ticks
  logic [7:0] dly_q, dly_d;
  logic sdo_q, sdo_d, sdoe_q, sdoe_d, clko_q, clko_d, clkoe_q, clkoe_d;
  assign sda_del = (sda_delay_select_i == DLY_NONE) ? dout_q : dly_q[sda_delay_select_i];
  always_comb begin
    dly_d = pre_tick ? {dly_q[6:0], dout_q} : dly_q;
    if (two_wire_mode_select_i) begin
      sdo_d = 1'b0;
      sdoe_d = !sda_disable_i && !sda_del;
      clko_d = 1'b0;
      clkoe_d = hold_q || (!dir && st_q == ST_SHIFT && !int_clk_q);
    end else begin
      sdo_d = sda_del;
      sdoe_d = active && transmit_enable_i;
      clko_d = int_clk_q;
      clkoe_d = active && !dir;
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dly_q <= 8'hff;
      sdo_q <= 1'b1;
      sdoe_q <= 1'b0;
      clko_q <= 1'b1;
      clkoe_q <= 1'b0;
    end else begin
      dly_q <= dly_d;
      sdo_q <= sdo_d;
      sdoe_q <= sdoe_d;
      clko_q <= clko_d;
      clkoe_q <= clkoe_d;
    end
  end

  assign serial_data_pin_o = sdo_q;
  assign serial_data_pin_oe_o = sdoe_q;
  assign serial_clock_pin_o = clko_q;
  assign serial_clock_pin_oe_o = clkoe_q;
  assign receive_buffer_o = rx_buf_q;
  assign rx_full_o = full_q;
  assign overrun_error_o = ovr_q;
  assign scl_wait_enable_o = swc_q;
  assign busy_o = (st_q == ST_SHIFT);
  assign tx_irq_o = txi_q;
  assign rx_irq_o = rxi_q;
  assign ack_irq_o = ack_q;
  assign nack_irq_o = nack_q;
  assign dma_req_o = {2{ack_q}} & dma_channel_enable_i;

  // Checks on the frame engine
  sequence s_start_init;
    start_init;
  endsequence
  sequence s_restarted;
    (st_q == ST_SHIFT) && (cnt_q == 4'h0) && (rx_sh_q == 8'h00);
  endsequence
  property p_start_restart;
    @(posedge clk_i) disable iff (!arst_n_i) s_start_init |=> s_restarted;
  endproperty
  a_start_restart: assert property (p_start_restart) else $error("start did not restart frame");
  property p_start_wait;
    @(posedge clk_i) disable iff (!arst_n_i) start_init |=> scl_wait_enable_o;
  endproperty
  a_start_wait: assert property (p_start_wait) else $error("start did not set scl wait");
  property p_start_no_pop;
    @(posedge clk_i) disable iff (!arst_n_i) start_init |-> !pop;
  endproperty
  a_start_no_pop: assert property (p_start_no_pop) else $error("start consumed the buffer");
  property p_sda_off;
    @(posedge clk_i) disable iff (!arst_n_i)
      (two_wire_mode_select_i && sda_disable_i)[*2] |-> !serial_data_pin_oe_o;
  endproperty
  a_sda_off: assert property (p_sda_off) else $error("sda driven while disabled");
  property p_sync_len;
    @(posedge clk_i) disable iff (!arst_n_i) (busy_o && !i2c) |-> cnt_q < BITS_SYNC;
  endproperty
  a_sync_len: assert property (p_sync_len) else $error("sync frame longer than eight");
  property p_ovr_slot;
    @(posedge clk_i) disable iff (!arst_n_i)
      $rose(overrun_error_o) |-> $past(samp_edge && cnt_q == OVR_SLOT && full_q);
  endproperty
  a_ovr_slot: assert property (p_ovr_slot) else $error("overrun at wrong bit");
  property p_ovr_no_rxi;
    @(posedge clk_i) disable iff (!arst_n_i) rx_irq_o |-> !ovf_q && full_q;
  endproperty
  a_ovr_no_rxi: assert property (p_ovr_no_rxi) else $error("receive irq after overrun");
  property p_txi_load;
    @(posedge clk_i) disable iff (!arst_n_i)
      (pop && !transmit_interrupt_source_select_i) |=> tx_irq_o;
  endproperty
  a_txi_load: assert property (p_txi_load) else $error("missing load transmit irq");
  property p_ack_excl;
    @(posedge clk_i) disable iff (!arst_n_i)
      (ack_irq_o || nack_irq_o) |-> !(ack_irq_o && nack_irq_o) && $past(i2c && !two_wire_rx_layout_select_i);
  endproperty
  a_ack_excl: assert property (p_ack_excl) else $error("bad ack or nack request");
endmodule

// [dv/ssm_peer.sv]
/*
  Bus peer model: shifts a byte toward the core and captures the core's data.
  Assumes an idle-high transfer clock: data moves on falls, is sampled on rises.
  The bit count restarts when the core turns busy, so idle clock moves between
  frames (mode or polarity changes) do not shift the next frame.
*/
`timescale 1ns/100ps
module ssm_peer (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic i2c_i,
  input wire logic [7:0] byte_i,
  input wire logic ack_i,
  input wire logic busy_i,
  output logic drv_o,
  output logic [7:0] cap_o
);
  int rc = 0;
  initial drv_o = 1'b1;
  // A new frame always starts at bit one
  always @(posedge busy_i) rc = 0;
  // Present the next bit while the clock is low; restart after a whole frame
  always @(negedge scl_i) begin
    if (rc >= (i2c_i ? 9 : 8)) rc = 0;
    if (rc < 8) drv_o = i2c_i ? 1'b1 : byte_i[7-rc];
    else drv_o = ack_i;
  end
  // Capture on the rise; a finished line no longer shows its last value
  always @(posedge scl_i) begin
    if (rc < 8) cap_o = {cap_o[6:0], sda_i};
    rc = rc + 1;
    if (rc == 8 && !i2c_i) drv_o = ~drv_o;
    if (rc == 9) drv_o = 1'b1;
  end
endmodule

// [dv/tb.sv]
/*
  Self-checking bench for the serial core: sync and I2C frames, FIFO fill.
  Assumes the peer model of ssm_peer.sv; open-drain lines are resolved here.
*/
`timescale 1ns/100ps
module tb import ssm_pkg::*;;
  logic clk_i = 0, arst_n_i = 0, two_wire_mode_select_i = 0, two_wire_rx_layout_select_i = 0;
  logic [2:0] serial_mode_select_i = SMD_OFF, sda_delay_select_i = DLY_NONE;
  logic sda_disable_i = 0, sda_init_i = 1, clock_phase_select_i = 0, clock_polarity_select_i = 0;
  logic condition_generation_select_i = 0, ack_force_enable_i = 0, ack_force_value_i = 0;
  logic start_initialisation_enable_i = 0, scl_wait_clear_i = 0, transmit_enable_i = 0;
  logic receive_enable_i = 0, clock_direction_select_i = 0, transmit_interrupt_source_select_i = 0;
  logic [7:0] baud_divider_i = 8'h07, tx_data_i = 8'h00, pbyte = 8'h3c, cap;
  logic [1:0] count_source_select_i = 2'h0, dma_channel_enable_i = 2'h2, dma_req_o, dma_seen;
  logic msb_first_i = 1, invert_data_i = 0, continuous_rx_i = 0, tx_valid_i = 0, rx_read_i = 0;
  logic overrun_clear_i = 0, tx_ready_o, rx_full_o, overrun_error_o, transmit_buffer_empty_flag_o;
  logic scl_wait_enable_o, busy_o, tx_irq_o, rx_irq_o, ack_irq_o, nack_irq_o, drv, pack = 0, st_n = 1;
  logic [8:0] receive_buffer_o;
  logic serial_data_pin_i, serial_data_pin_o, serial_data_pin_oe_o, prev = 0;
  logic serial_clock_pin_i, serial_clock_pin_o, serial_clock_pin_oe_o;
  int failures = 0, samples_checked = 0, cyc = 0, n_tx = 0, n_rx = 0, n_ack = 0, n_nack = 0;
  int per = 0, lastrise = 0, a0, b0;
  logic [8:0] exp_buf [5] = '{9'h096, 9'h04b, 9'h196, 9'h096, 9'h196};
  // Resolve the lines: pull-ups, open drain in I2C, start pulled by the bench
  wire line_w = (~serial_data_pin_oe_o | serial_data_pin_o) & (two_wire_mode_select_i ? drv & st_n : 1'b1);
  assign serial_data_pin_i = two_wire_mode_select_i ? line_w : drv;
  assign serial_clock_pin_i = ~serial_clock_pin_oe_o | serial_clock_pin_o;
  ssm_serial_port ssm_serial_port_i (.clk_i, .arst_n_i, .serial_mode_select_i, .two_wire_mode_select_i,
    .two_wire_rx_layout_select_i, .sda_delay_select_i, .sda_disable_i, .sda_init_i, .clock_phase_select_i,
    .clock_polarity_select_i, .condition_generation_select_i, .ack_force_enable_i, .ack_force_value_i,
    .start_initialisation_enable_i, .scl_wait_clear_i, .transmit_enable_i, .receive_enable_i,
    .clock_direction_select_i, .baud_divider_i, .count_source_select_i, .transmit_interrupt_source_select_i,
    .msb_first_i, .invert_data_i, .continuous_rx_i, .dma_channel_enable_i, .tx_valid_i, .tx_ready_o,
    .tx_data_i, .rx_read_i, .overrun_clear_i, .receive_buffer_o, .rx_full_o, .overrun_error_o,
    .transmit_buffer_empty_flag_o, .scl_wait_enable_o, .busy_o, .tx_irq_o, .rx_irq_o, .ack_irq_o,
    .nack_irq_o, .dma_req_o, .serial_data_pin_i, .serial_data_pin_o, .serial_data_pin_oe_o,
    .serial_clock_pin_i, .serial_clock_pin_o, .serial_clock_pin_oe_o);
  ssm_peer ssm_peer_i (.scl_i(serial_clock_pin_i), .sda_i(line_w), .i2c_i(two_wire_mode_select_i),
    .byte_i(pbyte), .ack_i(pack), .busy_i(busy_o), .drv_o(drv), .cap_o(cap));
  initial forever #4 clk_i = ~clk_i;
  // Count pulses, time clock rises, cut a hang short
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    n_tx <= n_tx + tx_irq_o;
    n_rx <= n_rx + rx_irq_o;
    n_ack <= n_ack + ack_irq_o;
    n_nack <= n_nack + nack_irq_o;
    if (ack_irq_o) dma_seen <= dma_req_o;
    prev <= serial_clock_pin_o;
    if (serial_clock_pin_o && !prev) begin
      per <= cyc - lastrise;
      lastrise <= cyc;
    end
    if (cyc == 20000) begin
      failures++;
      report_and_stop;
    end
  end
  // Expected line order of an LSB-first inverted byte
  function automatic logic [7:0] irev(input logic [7:0] d);
    for (int i = 0; i < 8; i++) irev[i] = ~d[7-i];
  endfunction
  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // FIFO write, held until ready is seen
  task automatic push(input logic [7:0] d);
    @(negedge clk_i);
    tx_valid_i = 1;
    tx_data_i = d;
    while (tx_ready_o !== 1'b1) @(negedge clk_i);
    @(negedge clk_i);
    tx_valid_i = 0;
  endtask
  task automatic frame_wait;
    while (busy_o !== 1'b1) @(negedge clk_i);
    while (busy_o !== 1'b0) @(negedge clk_i);
    repeat (4) @(negedge clk_i);
  endtask
  // Read the receive buffer and clear the overrun flag
  task automatic rd;
    @(negedge clk_i);
    rx_read_i = 1;
    overrun_clear_i = 1;
    @(negedge clk_i);
    rx_read_i = 0;
    overrun_clear_i = 0;
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk_i);
    arst_n_i = 1;
    two_wire_mode_select_i = 1;
    sda_init_i = 0;
    repeat (6) @(negedge clk_i);
    serial_mode_select_i = SMD_I2C;
    sda_disable_i = 1;
    repeat (4) @(negedge clk_i);
    check("sda_oe", 9'h0, serial_data_pin_oe_o);
    // Synchronous master, idle clock level, then MSB-first frame
    two_wire_mode_select_i = 0;
    sda_disable_i = 0;
    sda_init_i = 1;
    serial_mode_select_i = SMD_SYNC;
    clock_polarity_select_i = 1;
    repeat (6) @(negedge clk_i);
    check("clk_idle", 9'h0, serial_clock_pin_o);
    clock_polarity_select_i = 0;
    transmit_enable_i = 1;
    receive_enable_i = 1;
    push(8'ha5);
    frame_wait;
    check("tx_bits", 9'h0a5, cap);
    check("rx_byte", 9'h03c, receive_buffer_o[7:0]);
    check("clk_period", 9'd16, per[8:0]);
    check("tx_irq", 9'd1, n_tx[8:0]);
    check("rx_irq", 9'd1, n_rx[8:0]);
    check("rx_full", 9'h1, rx_full_o);
    // LSB first with inverted data
    rd;
    msb_first_i = 0;
    invert_data_i = 1;
    pbyte = 8'h1e;
    push(8'h35);
    frame_wait;
    check("lsb_inv_tx", irev(8'h35), cap);
    check("lsb_inv_rx", irev(8'h1e), receive_buffer_o[7:0]);
    // Unread buffer: overrun, no receive pulse
    transmit_interrupt_source_select_i = 1;
    push(8'h00);
    frame_wait;
    check("overrun", 9'h1, overrun_error_o);
    check("rx_irq_held", 9'd2, n_rx[8:0]);
    check("tx_irq_end", 9'd3, n_tx[8:0]);
    // Fill the FIFO while stalled, then drain it in order
    rd;
    transmit_enable_i = 0;
    for (int i = 0; i < FIFO_DEPTH; i++) push(i[7:0]);
    @(negedge clk_i);
    check("fifo_full", 9'h0, tx_ready_o);
    check("empty_flag", 9'h0, transmit_buffer_empty_flag_o);
    transmit_enable_i = 1;
    while (n_tx < 3 + FIFO_DEPTH) @(negedge clk_i);
    repeat (8) @(negedge clk_i);
    check("fifo_drained", 9'h1, transmit_buffer_empty_flag_o);
    check("last_word", irev(8'h1f), cap);
    // I2C frames: layouts, phase, forced ack, nack
    msb_first_i = 1;
    invert_data_i = 0;
    transmit_interrupt_source_select_i = 0;
    serial_mode_select_i = SMD_I2C;
    two_wire_mode_select_i = 1;
    for (int k = 0; k < 5; k++) begin
      two_wire_rx_layout_select_i = (k == 1 || k == 2);
      clock_phase_select_i = (k == 2);
      ack_force_enable_i = (k == 3);
      pack = (k != 0);
      a0 = n_ack;
      b0 = n_nack;
      rd;
      push(8'h96);
      frame_wait;
      check("i2c_tx", 9'h096, cap);
      check("i2c_rx", exp_buf[k], receive_buffer_o);
      check("ack_irq", 9'((k == 0 || k == 3) ? 1 : 0), 9'(n_ack - a0));
      check("nack_irq", 9'((k == 4) ? 1 : 0), 9'(n_nack - b0));
    end
    check("dma_req", 9'h2, dma_seen);
    // Start condition on an idle bus restarts without popping
    transmit_enable_i = 0;
    clock_direction_select_i = 1;
    start_initialisation_enable_i = 1;
    push(8'h5a);
    repeat (4) @(negedge clk_i);
    st_n = 0;
    repeat (10) @(negedge clk_i);
    check("scl_wait", 9'h1, scl_wait_enable_o);
    check("start_flag", 9'h0, transmit_buffer_empty_flag_o);
    st_n = 1;
    scl_wait_clear_i = 1;
    @(negedge clk_i);
    scl_wait_clear_i = 0;
    repeat (2) @(negedge clk_i);
    check("scl_wait_clr", 9'h0, scl_wait_enable_o);
    report_and_stop;
  end
endmodule
